/* src/dcf_map.svh */
`ifndef DCF_MAP_SVH
`define DCF_MAP_SVH
`define DCF_REG_STATUS 4'h0
`define DCF_REG_AE_OFS 4'h4
`define DCF_REG_AF_OFS 4'h8
`define DCF_ST_LEVEL_LSB 16
`define DCF_AE_RESET 18'h0007F
`define DCF_AF_RESET 18'h0007F
`define DCF_FLAGS_RESET 5'h1A
`define DCF_RESP_OKAY 2'h0
`define DCF_RESP_SLVERR 2'h2
`define DCF_DEPTH 8192
`define DCF_DATA_W 18
`endif

/* src/dcf_pkg.sv */
package dcf_pkg;
  typedef struct packed {
    logic half_full_n;
    logic almost_full_n;
    logic almost_empty_n;
    logic full_flag_n;
    logic empty_flag_n;
  } dcf_flags_type;
  typedef enum logic {
    DCF_SEL_AE = 1'b0,
    DCF_SEL_AF = 1'b1
  } dcf_sel_type;
endpackage : dcf_pkg

/* src/dcf_fifo.sv */
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "dcf_map.svh"
module dcf_fifo #(
  parameter int DEPTH = `DCF_DEPTH,
  parameter int DW = `DCF_DATA_W,
  parameter int AXI_AW = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [DW-1:0] data_in,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic offset_load_n,
  input wire logic retransmit,
  input wire logic first_load_n,
  input wire logic cascade_mode,
  input wire logic write_expansion_in,
  input wire logic read_expansion_in,
  input wire logic flag_sync_mode_n,
  input wire logic output_enable_n,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic write_expansion_out,
  output logic read_expansion_out,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;
  localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);
  localparam logic [LW-1:0] HALF_LVL = LW'(DEPTH / 2);

  function automatic logic [LW-1:0] lvl_fn(input logic [LW-1:0] w, input logic [LW-1:0] r);
    lvl_fn = w - r;
  endfunction : lvl_fn

  function automatic logic [DW-1:0] merge_fn(input logic [DW-1:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = {14'h0000, old};
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge_fn = m[DW-1:0];
  endfunction : merge_fn

  // ****************************************
  // Buffer, pointers and flags
  // ****************************************
  logic [DW-1:0] mem [DEPTH];
  logic [LW-1:0] wr_q, wr_d, rd_q, rd_d, level_q, level_d;
  logic [DW-1:0] dout_q, dout_d, ae_ofs_q, ae_ofs_d, af_ofs_q, af_ofs_d;
  dcf_pkg::dcf_sel_type wsel_q, wsel_d, rsel_q, rsel_d;
  dcf_pkg::dcf_flags_type flg_q, flg_d;
  logic wtok_q, wtok_d, rtok_q, rtok_d, wxo_q, wxo_d, rxo_q, rxo_d;
  logic wr_ok, rd_ok, ae_now, af_now;
  logic ax_wr, ax_ae, ax_af;

  assign level_q = lvl_fn(wr_q, rd_q);
  assign wr_ok = !write_enable_n && offset_load_n && level_q != FULL_LVL && wtok_q;
  assign rd_ok = !read_enable_n && offset_load_n && level_q != '0 && rtok_q;
  assign ae_now = level_q <= LW'(ae_ofs_q);
  assign af_now = level_q >= FULL_LVL - LW'(af_ofs_q);

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    dout_d = dout_q;
    wsel_d = wsel_q;
    rsel_d = rsel_q;
    ae_ofs_d = ae_ofs_q;
    af_ofs_d = af_ofs_q;
    wtok_d = wtok_q;
    rtok_d = rtok_q;
    wxo_d = 1'b0;
    rxo_d = 1'b0;
    // Held write word, the bus may have moved on
    if (ax_wr && ax_ae) begin
      ae_ofs_d = merge_fn(ae_ofs_q, wd_q, ws_q);
    end
    if (ax_wr && ax_af) begin
      af_ofs_d = merge_fn(af_ofs_q, wd_q, ws_q);
    end
    if (!offset_load_n && !write_enable_n) begin
      if (wsel_q == dcf_pkg::DCF_SEL_AE) begin
        ae_ofs_d = data_in;
        wsel_d = dcf_pkg::DCF_SEL_AF;
      end else begin
        af_ofs_d = data_in;
        wsel_d = dcf_pkg::DCF_SEL_AE;
      end
    end
    if (!offset_load_n && !read_enable_n) begin
      dout_d = (rsel_q == dcf_pkg::DCF_SEL_AE) ? ae_ofs_q : af_ofs_q;
      rsel_d = (rsel_q == dcf_pkg::DCF_SEL_AE) ? dcf_pkg::DCF_SEL_AF : dcf_pkg::DCF_SEL_AE;
    end
    if (wr_ok) begin
      wr_d = wr_q + 1'b1;
    end
    if (rd_ok) begin
      dout_d = mem[rd_q[AW-1:0]];
      rd_d = rd_q + 1'b1;
    end
    if (retransmit && !cascade_mode) begin
      rd_d = '0;
    end
    if (cascade_mode) begin
      // Write token leaves with the word that fills this device
      if (wr_ok && lvl_fn(wr_d, rd_d) == FULL_LVL) begin
        wtok_d = 1'b0;
        wxo_d = 1'b1;
      end
      if (write_expansion_in) begin
        wtok_d = 1'b1;
      end
      // Read token leaves with the last word once writing moved on
      if (rd_ok && lvl_fn(wr_d, rd_d) == '0 && !wtok_q) begin
        rtok_d = 1'b0;
        rxo_d = 1'b1;
      end
      if (read_expansion_in) begin
        rtok_d = 1'b1;
      end
    end else begin
      wtok_d = 1'b1;
      rtok_d = 1'b1;
    end
    level_d = lvl_fn(wr_d, rd_d);
    flg_d.empty_flag_n = level_d != '0;
    flg_d.full_flag_n = level_d != FULL_LVL;
    flg_d.almost_empty_n = level_d > LW'(ae_ofs_d);
    flg_d.almost_full_n = level_d < FULL_LVL - LW'(af_ofs_d);
    flg_d.half_full_n = level_d <= HALF_LVL;
  end

  always_ff @(posedge aclk) begin
    if (wr_ok) begin
      mem[wr_q[AW-1:0]] <= data_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
      dout_q <= '0;
      wsel_q <= dcf_pkg::DCF_SEL_AE;
      rsel_q <= dcf_pkg::DCF_SEL_AE;
      ae_ofs_q <= `DCF_AE_RESET;
      af_ofs_q <= `DCF_AF_RESET;
      flg_q <= `DCF_FLAGS_RESET;
      // First-load strap decides which device starts with both tokens
      wtok_q <= !cascade_mode || !first_load_n;
      rtok_q <= !cascade_mode || !first_load_n;
      wxo_q <= 1'b0;
      rxo_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      dout_q <= dout_d;
      wsel_q <= wsel_d;
      rsel_q <= rsel_d;
      ae_ofs_q <= ae_ofs_d;
      af_ofs_q <= af_ofs_d;
      flg_q <= flg_d;
      wtok_q <= wtok_d;
      rtok_q <= rtok_d;
      wxo_q <= wxo_d;
      rxo_q <= rxo_d;
    end
  end

  assign data_out = dout_q;
  assign data_oe = !output_enable_n;
  assign empty_flag_n = flg_q.empty_flag_n;
  assign full_flag_n = flg_q.full_flag_n;
  assign almost_empty_n = flag_sync_mode_n ? !ae_now : flg_q.almost_empty_n;
  assign almost_full_n = flag_sync_mode_n ? !af_now : flg_q.almost_full_n;
  assign write_expansion_out = cascade_mode ? wxo_q : flg_q.half_full_n;
  assign read_expansion_out = rxo_q;

  // ****************************************
  // AXI4-Lite register slave
  // ****************************************
  logic aw_v_q, aw_v_d, w_v_q, w_v_d, b_v_q, b_v_d, r_v_q, r_v_d;
  logic [AXI_AW-1:0] aw_a_q, aw_a_d;
  logic [31:0] wd_q, wd_d, rd_data_q, rd_data_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  assign s_axi_awready = !aw_v_q && !b_v_q;
  assign s_axi_wready = !w_v_q && !b_v_q;
  assign s_axi_arready = !r_v_q;
  assign ax_wr = aw_v_q && w_v_q && !b_v_q;
  assign ax_ae = aw_a_q == AXI_AW'(`DCF_REG_AE_OFS);
  assign ax_af = aw_a_q == AXI_AW'(`DCF_REG_AF_OFS);

  always_comb begin
    aw_v_d = aw_v_q;
    w_v_d = w_v_q;
    b_v_d = b_v_q;
    r_v_d = r_v_q;
    aw_a_d = aw_a_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    rd_data_d = rd_data_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_v_d = 1'b1;
      aw_a_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_v_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (ax_wr) begin
      aw_v_d = 1'b0;
      w_v_d = 1'b0;
      b_v_d = 1'b1;
      bresp_d = (ax_ae || ax_af) ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
    end
    if (b_v_q && s_axi_bready) begin
      b_v_d = 1'b0;
    end
    if (r_v_q && s_axi_rready) begin
      r_v_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_v_d = 1'b1;
      rresp_d = `DCF_RESP_OKAY;
      unique case (s_axi_araddr)
        AXI_AW'(`DCF_REG_STATUS): begin
          rd_data_d = {16'h0000, 11'h000, flg_q};
          rd_data_d[`DCF_ST_LEVEL_LSB +: LW] = level_q;
        end
        AXI_AW'(`DCF_REG_AE_OFS): rd_data_d = {14'h0000, ae_ofs_q};
        AXI_AW'(`DCF_REG_AF_OFS): rd_data_d = {14'h0000, af_ofs_q};
        default: begin
          rd_data_d = 32'h00000000;
          rresp_d = `DCF_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      b_v_q <= 1'b0;
      r_v_q <= 1'b0;
      aw_a_q <= '0;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bresp_q <= `DCF_RESP_OKAY;
      rresp_q <= `DCF_RESP_OKAY;
      rd_data_q <= 32'h00000000;
    end else begin
      aw_v_q <= aw_v_d;
      w_v_q <= w_v_d;
      b_v_q <= b_v_d;
      r_v_q <= r_v_d;
      aw_a_q <= aw_a_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign s_axi_bvalid = b_v_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = r_v_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rd_data_q;

  // ****************************************
  // Checks
  // ****************************************
  empty_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (empty_flag_n == (level_q != '0))) else $error("empty flag disagrees with level");
  full_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (full_flag_n == (level_q != FULL_LVL))) else $error("full flag disagrees with level");
  full_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!full_flag_n && !retransmit |=> wr_q == $past(wr_q))) else $error("write while full");
  read_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_ok && !retransmit |=> rd_q == $past(rd_q) + 1'b1 && level_q == $past(level_q) - 1'b1 + LW'($past(wr_ok))))
    else $error("read did not advance");
  ofs_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!offset_load_n && !write_enable_n && wsel_q == dcf_pkg::DCF_SEL_AE |=> ae_ofs_q == $past(data_in)))
    else $error("offset load lost");
  ofs_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!offset_load_n && !read_enable_n && rsel_q == dcf_pkg::DCF_SEL_AF |=> data_out == $past(af_ofs_q)))
    else $error("offset readback wrong");
  ae_async_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_sync_mode_n && level_q <= LW'(ae_ofs_q) |-> !almost_empty_n)) else $error("almost empty missed");
  retx_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (retransmit && !cascade_mode |=> rd_q == '0)) else $error("retransmit start wrong");
  reset_empty_a: assert property (@(posedge aclk)
    (!aresetn |=> level_q == '0 && !empty_flag_n && full_flag_n)) else $error("reset not empty");
  oe_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(output_enable_n) |-> data_oe)) else $error("outputs not driven");
endmodule : dcf_fifo

/* testbench/dcf_ring.sv */
`timescale 1ns/1ps
// ****
// Cascade ring of one device
// ****
module dcf_ring (
  input wire logic aclk,
  input wire logic cascade_mode,
  input wire logic write_expansion_out,
  input wire logic read_expansion_out,
  output logic write_expansion_in,
  output logic read_expansion_in,
  output int wx_seen
);
  initial begin
    write_expansion_in = 1'b0;
    read_expansion_in = 1'b0;
    wx_seen = 0;
  end
  // Last device hands tokens back to the first; held low when standalone
  always @(posedge aclk) begin
    write_expansion_in <= cascade_mode & write_expansion_out;
    read_expansion_in <= cascade_mode & read_expansion_out;
    if (cascade_mode && write_expansion_out) begin
      wx_seen <= wx_seen + 1;
    end
  end
endmodule : dcf_ring

/* testbench/dcf_fifo_tb.sv */
`timescale 1ns/1ps
`include "dcf_map.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module dcf_fifo_tb;
  logic aclk = 1'b0, aresetn = 1'b0, write_enable_n = 1'b1, read_enable_n = 1'b1;
  logic offset_load_n = 1'b1, retransmit = 1'b0, first_load_n = 1'b0, cascade_mode = 1'b0;
  logic flag_sync_mode_n = 1'b0, output_enable_n = 1'b0, write_expansion_in, read_expansion_in;
  logic [17:0] data_in = 18'h00000, data_out;
  logic data_oe, empty_flag_n, full_flag_n, almost_empty_n, almost_full_n;
  logic write_expansion_out, read_expansion_out;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int fail_count = 0, checks_done = 0, wx_seen, i;
  always #5 aclk = ~aclk;
  dcf_fifo #(.DEPTH(16)) DUT (.*);
  dcf_ring ring (.*);
  // ****
  // Bus and pin helpers
  // ****
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
  endtask : do_reset
  task automatic push(input logic [17:0] d, input logic ld);
    @(posedge aclk);
    data_in <= d;
    write_enable_n <= 1'b0;
    offset_load_n <= ld;
    @(posedge aclk);
    write_enable_n <= 1'b1;
    offset_load_n <= 1'b1;
    #1;
  endtask : push
  task automatic pop(input logic ld);
    @(posedge aclk);
    read_enable_n <= 1'b0;
    offset_load_n <= ld;
    @(posedge aclk);
    read_enable_n <= 1'b1;
    offset_load_n <= 1'b1;
    #1;
  endtask : pop
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(negedge aclk); while (s_axi_awready !== 1'b1);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(negedge aclk); while (s_axi_wready !== 1'b1);
        @(posedge aclk);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axr
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    `CHK("ef", 1'b0, empty_flag_n)
    `CHK("ff", 1'b1, full_flag_n)
    `CHK("ae", 1'b0, almost_empty_n)
    `CHK("hf", 1'b1, write_expansion_out)
    axr(`DCF_REG_STATUS, rd, rr);
    `CHK("status", 32'h0000001A, rd)
    $display("test reset done");
  endtask : t_reset
  task automatic t_offsets();
    push(18'h00002, 1'b0);
    push(18'h00003, 1'b0);
    pop(1'b0);
    `CHK("ae ofs", 18'h00002, data_out)
    pop(1'b0);
    `CHK("af ofs", 18'h00003, data_out)
    `CHK("ef", 1'b0, empty_flag_n)
    $display("test offsets done");
  endtask : t_offsets
  task automatic t_fill();
    @(posedge aclk);
    write_enable_n <= 1'b0;
    data_in <= 18'h00100;
    for (i = 1; i <= 17; i++) begin
      @(posedge aclk);
      data_in <= 18'h00100 + i;
      #1;
      `CHK("ef", 1'b1, empty_flag_n)
      `CHK("ff", (i < 16), full_flag_n)
      `CHK("af", (i < 13), almost_full_n)
      `CHK("ae", (i > 2), almost_empty_n)
      `CHK("hf", (i <= 8), write_expansion_out)
    end
    @(posedge aclk);
    write_enable_n <= 1'b1;
    $display("test fill done");
  endtask : t_fill
  task automatic t_drain();
    @(posedge aclk);
    flag_sync_mode_n <= 1'b1;
    read_enable_n <= 1'b0;
    for (i = 1; i <= 17; i++) begin
      @(posedge aclk);
      #1;
      `CHK("q", 18'h00100 + ((i > 16) ? 15 : i - 1), data_out)
      `CHK("ef", (i < 16), empty_flag_n)
      `CHK("ae", (16 - i > 2), almost_empty_n)
      `CHK("af", (16 - i < 13), almost_full_n)
    end
    @(posedge aclk);
    read_enable_n <= 1'b1;
    $display("test drain done");
  endtask : t_drain
  task automatic t_axi();
    axr(`DCF_REG_AE_OFS, rd, rr);
    `CHK("ae reg", 32'h00000002, rd)
    axw(`DCF_REG_AF_OFS, 32'h00000005, rr);
    `CHK("bresp", `DCF_RESP_OKAY, rr)
    axr(`DCF_REG_AF_OFS, rd, rr);
    `CHK("af reg", 32'h00000005, rd)
    axw(`DCF_REG_STATUS, 32'h00000001, rr);
    `CHK("ro bresp", `DCF_RESP_SLVERR, rr)
    axr(4'hC, rd, rr);
    `CHK("unmapped", `DCF_RESP_SLVERR, rr)
    `CHK("unmapped data", 32'h00000000, rd)
    @(posedge aclk);
    output_enable_n <= 1'b1;
    #1;
    `CHK("oe off", 1'b0, data_oe)
    @(posedge aclk);
    output_enable_n <= 1'b0;
    #1;
    `CHK("oe on", 1'b1, data_oe)
    $display("test axi and oe done");
  endtask : t_axi
  task automatic t_retx();
    push(18'h00011, 1'b1);
    push(18'h00022, 1'b1);
    push(18'h00033, 1'b1);
    pop(1'b1);
    pop(1'b1);
    @(posedge aclk);
    retransmit <= 1'b1;
    @(posedge aclk);
    retransmit <= 1'b0;
    for (i = 0; i < 3; i++) begin
      pop(1'b1);
      `CHK("replay", 18'h00011 * (i + 1), data_out)
    end
    `CHK("ef", 1'b0, empty_flag_n)
    $display("test retransmit done");
  endtask : t_retx
  task automatic t_casc();
    @(posedge aclk);
    cascade_mode <= 1'b1;
    first_load_n <= 1'b0;
    do_reset();
    @(posedge aclk);
    write_enable_n <= 1'b0;
    repeat (16) @(posedge aclk);
    write_enable_n <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
    `CHK("ff", 1'b0, full_flag_n)
    `CHK("wx token", 1, wx_seen)
    `CHK("rx token", 1'b0, read_expansion_out)
    $display("test cascade done");
  endtask : t_casc
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
  initial begin
    do_reset();
    t_reset();
    t_offsets();
    t_fill();
    t_drain();
    t_axi();
    do_reset();
    t_retx();
    t_casc();
    wrap_up();
  end
endmodule : dcf_fifo_tb
